// ==== dual_port_comm_consts.vh ====
// constants for the dual-port communications control and status block
`ifndef DUAL_PORT_COMM_CONSTS_VH
`define DUAL_PORT_COMM_CONSTS_VH

// ---------------------------------------------------------------------------
// instruction decode
// ---------------------------------------------------------------------------
// upper nine bits of the io transfer instruction word, octal 636
`define IOT_DEVICE_BASE     9'h19E
// low octal digit of the instruction, octal 6360 .. 6367
`define FN_SET_MODEM_FLAG   3'h0
`define FN_SKIP_MODEM_FLAG  3'h1
`define FN_WRITE_CTRL0      3'h2
`define FN_READ_STATUS      3'h3
`define FN_READ_MODEM       3'h4
`define FN_LOAD_IRQ_ENABLE  3'h5
`define FN_WRITE_CTRL1      3'h6
`define FN_RESET_DEVICE     3'h7

// ---------------------------------------------------------------------------
// accumulator bit positions, bit 0 is the most significant
// ---------------------------------------------------------------------------
`define AC_PORT_SEL         0
`define AC_IRQ_ENABLE       11

// ---------------------------------------------------------------------------
// port control register fields
// ---------------------------------------------------------------------------
`define CTL_TERM_TIMING     4
`define CTL_ESD_TX_ENABLE   5
`define CTL_ESD_RX_ENABLE   6
`define CTL_REQ_TO_SEND     7
`define CTL_TERM_READY      8
`define CTL_SIGNAL_RATE     9
`define CTL_MAINT_SELECT    10
`define CTL_DEVICE_SELECT   11
// bits 0..3 are unused and are not stored
`define CTL_WRITE_MASK      12'h0FF
`define CTL_RESET_VALUE     12'h000

// ---------------------------------------------------------------------------
// port status word fields
// ---------------------------------------------------------------------------
`define ST_PORT_ECHO        0
`define ST_ZERO             1
`define ST_ESD_TX_ACTIVE    2
`define ST_ESD_RX_ACTIVE    3
`define ST_ESD_TX_EMPTY     4
`define ST_SCD_TX_EMPTY_N   5
`define ST_ESD_RX_AVAIL     6
`define ST_SCD_RX_AVAIL_N   7
`define ST_ESD_TX_STATUS    8
`define ST_ESD_RX_STATUS    9
`define ST_DEVICE_SELECT    10
`define ST_ESD_ABSENT       11

// ---------------------------------------------------------------------------
// modem register word fields
// ---------------------------------------------------------------------------
`define MD_PORT_ECHO        0
`define MD_ZERO_FIRST       1
`define MD_ZERO_LAST        3
`define MD_REQ_TO_SEND      4
`define MD_TERM_READY       5
`define MD_SIGNAL_RATE      6
`define MD_SIGNAL_QUALITY   7
`define MD_INCOMING_CALL    8
`define MD_RECEIVER_READY   9
`define MD_DATA_MODE        10
`define MD_CLEAR_TO_SEND    11
`define MD_INPUT_COUNT      5

`endif

// ==== port_word_builder.v ====
// forms the status word and the modem word of one communications port
`timescale 1ns/1ns
`include "dual_port_comm_consts.vh"

module port_word_builder (
  input  wire        portId,
  input  wire        deviceSelect,
  input  wire        requestToSend,
  input  wire        terminalReady,
  input  wire        signalRate,
  input  wire        esdFitted,
  input  wire        esdTxActive,
  input  wire        esdRxActive,
  input  wire        esdTxEmpty,
  input  wire        scdTxEmptyN,
  input  wire        esdRxAvail,
  input  wire        scdRxAvailN,
  input  wire        esdTxStatAvail,
  input  wire        esdRxStatAvail,
  input  wire [4:0]  modemInputs,
  output wire [0:11] statusWord,
  output wire [0:11] modemWord
);

  // ---------------------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------------------
  // an empty socket floats its enhanced-device lines high, so force them
  assign statusWord[`ST_PORT_ECHO]      = portId;
  assign statusWord[`ST_ZERO]           = 1'b0;
  assign statusWord[`ST_ESD_TX_ACTIVE]  = esdTxActive | ~esdFitted;
  assign statusWord[`ST_ESD_RX_ACTIVE]  = esdRxActive | ~esdFitted;
  assign statusWord[`ST_ESD_TX_EMPTY]   = esdTxEmpty | ~esdFitted;
  assign statusWord[`ST_SCD_TX_EMPTY_N] = scdTxEmptyN;
  assign statusWord[`ST_ESD_RX_AVAIL]   = esdRxAvail | ~esdFitted;
  assign statusWord[`ST_SCD_RX_AVAIL_N] = scdRxAvailN;
  assign statusWord[`ST_ESD_TX_STATUS]  = esdTxStatAvail | ~esdFitted;
  assign statusWord[`ST_ESD_RX_STATUS]  = esdRxStatAvail | ~esdFitted;
  assign statusWord[`ST_DEVICE_SELECT]  = deviceSelect;
  assign statusWord[`ST_ESD_ABSENT]     = ~esdFitted;

  // ---------------------------------------------------------------------------
  // modem word
  // ---------------------------------------------------------------------------
  // outputs echo the control register, inputs come straight from the lines
  assign modemWord[`MD_PORT_ECHO]       = portId;
  assign modemWord[`MD_ZERO_FIRST:`MD_ZERO_LAST] = 3'h0;
  assign modemWord[`MD_REQ_TO_SEND]     = requestToSend;
  assign modemWord[`MD_TERM_READY]      = terminalReady;
  assign modemWord[`MD_SIGNAL_RATE]     = signalRate;
  assign modemWord[`MD_SIGNAL_QUALITY:`MD_CLEAR_TO_SEND] = modemInputs;

endmodule // port_word_builder

// ==== dual_port_comm_control_status.v ====
// port control, port status and modem register logic for two serial ports
//
// Overview of operation
// - Status read clears accumulator, returns status of port chosen by bit 0.
// - Status bit 0 echoes the port number; bit 1 always reads zero.
// - Status bits 2, 3 show enhanced transmitter and receiver active.
// - Bit 4 enhanced transmit buffer empty; bit 5 low when standard empty.
// - Bit 6 enhanced data available; bit 7 low when standard data available.
// - Bits 8, 9 show enhanced transmitter and receiver status available.
// - Bit 10 shows device selected; bit 11 low when enhanced device fitted.
// - With no enhanced device fitted, all its status signals read one.
// - Modem read clears accumulator, returns chosen port; bits 1-3 zero.
// - Modem bits 4-6: request to send, terminal ready, signalling rate.
// - Modem bits 7-11: quality, incoming call, ready, data mode, clear.
// - Interrupt enable load takes accumulator bit 11, ignores bits 0-10.
// - Port 1 control write loads register, accumulator left unchanged.
// - Control bits 4-10 are the port enables and modem outputs.
// - Control bit 11 picks standard (0) or enhanced (1) device.
// - Reset-active-device acts on port in bit 0, ignores bits 1-11.
// - Reset-active-device clears the port's serial device registers.
// - Port 0 control write loads register, accumulator left unchanged.
// - Set instruction raises modem change flag; skip instruction tests it.
`timescale 1ns/1ns
`include "dual_port_comm_consts.vh"

module dual_port_comm_control_status #(
  parameter PORTS = 2
) (
  input  wire             clock,
  input  wire             reset,
  // io transfer instruction from the processor
  input  wire             iotStrobe,
  input  wire [11:0]      iotCode,
  input  wire [0:11]      accIn,
  output wire             ioDone,
  output wire [0:11]      accOut,
  output wire             accLoad,
  output wire             skipTaken,
  // serial device state, one bit per port
  input  wire [PORTS-1:0] esdFitted,
  input  wire [PORTS-1:0] esdTxActive,
  input  wire [PORTS-1:0] esdRxActive,
  input  wire [PORTS-1:0] esdTxEmpty,
  input  wire [PORTS-1:0] scdTxEmptyN,
  input  wire [PORTS-1:0] esdRxAvail,
  input  wire [PORTS-1:0] scdRxAvailN,
  input  wire [PORTS-1:0] esdTxStatAvail,
  input  wire [PORTS-1:0] esdRxStatAvail,
  // modem inputs, one bit per port
  input  wire [PORTS-1:0] signalQuality,
  input  wire [PORTS-1:0] incomingCall,
  input  wire [PORTS-1:0] receiverReady,
  input  wire [PORTS-1:0] dataMode,
  input  wire [PORTS-1:0] clearToSend,
  // control register fields, one bit per port
  output wire [PORTS-1:0] termTimingEnable,
  output wire [PORTS-1:0] esdTxEnable,
  output wire [PORTS-1:0] esdRxEnable,
  output wire [PORTS-1:0] requestToSend,
  output wire [PORTS-1:0] terminalReady,
  output wire [PORTS-1:0] signalRate,
  output wire [PORTS-1:0] maintSelect,
  output wire [PORTS-1:0] deviceSelect,
  // one-cycle clear of the serial devices of a port
  output wire [PORTS-1:0] resetActiveDevice,
  // modem change flag and its interrupt
  output wire             modemChangeFlag,
  output wire             modemIrqEnable,
  output wire             modemIrq
);

  // ---------------------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------------------
  wire       iotHit;
  wire [2:0] iotFunction;
  wire       portSel;
  // arming flop of the change detector, read inside the port loop below
  reg        armed_q;

  // only octal 6360..6367 belong to this block
  assign iotHit      = iotStrobe & (iotCode[11:3] == `IOT_DEVICE_BASE);
  assign iotFunction = iotCode[2:0];
  // the port is taken from the accumulator as it stood before the transfer
  assign portSel     = accIn[`AC_PORT_SEL];

  // ---------------------------------------------------------------------------
  // per-port control, word forming and modem change detection
  // ---------------------------------------------------------------------------
  wire [0:12*PORTS-1] statusAll;
  wire [0:12*PORTS-1] modemAll;
  wire [PORTS-1:0]    modemChanged;

  genvar i;
  generate
    for (i = 0; i < PORTS; i = i + 1) begin : port
      reg  [0:11] ctrl_q;
      reg  [4:0]  prevModem_q;
      wire [4:0]  modemNow;
      wire        writeCtrl;
      wire [2:0]  ctrlFunction;

      // port 0 and port 1 have their own write codes
      assign ctrlFunction = (i == 0) ? `FN_WRITE_CTRL0 : `FN_WRITE_CTRL1;
      assign writeCtrl    = iotHit & (iotFunction == ctrlFunction);

      // control register, bits 0..3 dropped since nothing uses them
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          ctrl_q <= `CTL_RESET_VALUE;
        end else if (writeCtrl) begin
          ctrl_q <= accIn & `CTL_WRITE_MASK;
        end
      end

      assign termTimingEnable[i] = ctrl_q[`CTL_TERM_TIMING];
      assign esdTxEnable[i]      = ctrl_q[`CTL_ESD_TX_ENABLE];
      assign esdRxEnable[i]      = ctrl_q[`CTL_ESD_RX_ENABLE];
      assign requestToSend[i]    = ctrl_q[`CTL_REQ_TO_SEND];
      assign terminalReady[i]    = ctrl_q[`CTL_TERM_READY];
      assign signalRate[i]       = ctrl_q[`CTL_SIGNAL_RATE];
      assign maintSelect[i]      = ctrl_q[`CTL_MAINT_SELECT];
      assign deviceSelect[i]     = ctrl_q[`CTL_DEVICE_SELECT];

      // modem inputs in the order they appear in the modem word
      assign modemNow = {signalQuality[i], incomingCall[i],
                         receiverReady[i], dataMode[i], clearToSend[i]};

      // previous sample; inputs are synchronous so one stage is enough
      always @(posedge clock or posedge reset) begin
        if (reset) begin
          prevModem_q <= 5'h00;
        end else begin
          prevModem_q <= modemNow;
        end
      end

      // armed_q masks the first compare, whose old sample is only a reset value
      assign modemChanged[i] = armed_q & (modemNow != prevModem_q);

      // the echo bit is the loop index, one bit wide for two ports
      port_word_builder words (
        .portId         ((i == 1) ? 1'b1 : 1'b0),
        .deviceSelect   (ctrl_q[`CTL_DEVICE_SELECT]),
        .requestToSend  (ctrl_q[`CTL_REQ_TO_SEND]),
        .terminalReady  (ctrl_q[`CTL_TERM_READY]),
        .signalRate     (ctrl_q[`CTL_SIGNAL_RATE]),
        .esdFitted      (esdFitted[i]),
        .esdTxActive    (esdTxActive[i]),
        .esdRxActive    (esdRxActive[i]),
        .esdTxEmpty     (esdTxEmpty[i]),
        .scdTxEmptyN    (scdTxEmptyN[i]),
        .esdRxAvail     (esdRxAvail[i]),
        .scdRxAvailN    (scdRxAvailN[i]),
        .esdTxStatAvail (esdTxStatAvail[i]),
        .esdRxStatAvail (esdRxStatAvail[i]),
        .modemInputs    (modemNow),
        .statusWord     (statusAll[12*i +: 12]),
        .modemWord      (modemAll[12*i +: 12])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // change detector arming
  // ---------------------------------------------------------------------------
  // armed_q sits with the decode wires so the port loop sees it first

  // held off for one cycle after reset so the first sample is not a change
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // modem change flag and interrupt enable
  // ---------------------------------------------------------------------------
  reg  flag_q;
  reg  flag_d;
  reg  irqEnable_q;
  wire flagSet;
  wire flagClear;

  assign flagSet   = (iotHit & (iotFunction == `FN_SET_MODEM_FLAG))
                     | (|modemChanged);
  assign flagClear = iotHit & (iotFunction == `FN_SKIP_MODEM_FLAG);

  // a change arriving with the skip is kept: set beats clear
  always @* begin
    flag_d = flag_q;
    if (flagSet) begin
      flag_d = 1'b1;
    end else if (flagClear) begin
      flag_d = 1'b0;
    end
  end

  // modem change flag register
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // only accumulator bit 11 matters for the enable load
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irqEnable_q <= 1'b0;
    end else if (iotHit & (iotFunction == `FN_LOAD_IRQ_ENABLE)) begin
      irqEnable_q <= accIn[`AC_IRQ_ENABLE];
    end
  end

  assign modemChangeFlag = flag_q;
  assign modemIrqEnable  = irqEnable_q;
  assign modemIrq        = flag_q & irqEnable_q;

  // ---------------------------------------------------------------------------
  // instruction answer
  // ---------------------------------------------------------------------------
  reg          done_q;
  reg  [0:11]  accOut_q;
  reg          accLoad_q;
  reg          skip_q;
  reg  [0:11]  accOut_d;
  reg          accLoad_d;
  wire [0:11]  statusSel;
  wire [0:11]  modemSel;

  // only two ports exist, so accumulator bit 0 picks one of two words
  assign statusSel = portSel ? statusAll[12 +: 12] : statusAll[0 +: 12];
  assign modemSel  = portSel ? modemAll[12 +: 12]  : modemAll[0 +: 12];

  // reads replace the accumulator outright, which is the clear-then-load
  always @* begin
    accOut_d  = accIn;
    accLoad_d = 1'b0;
    case (iotFunction)
      `FN_READ_STATUS: begin
        accOut_d  = statusSel;
        accLoad_d = 1'b1;
      end
      `FN_READ_MODEM: begin
        accOut_d  = modemSel;
        accLoad_d = 1'b1;
      end
      default: begin
        accOut_d  = accIn;
        accLoad_d = 1'b0;
      end
    endcase
  end

  // answer: one-cycle pulses, accOut holds until the next taken instruction
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      done_q    <= 1'b0;
      accOut_q  <= 12'h000;
      accLoad_q <= 1'b0;
      skip_q    <= 1'b0;
    end else begin
      done_q    <= iotHit;
      accLoad_q <= iotHit & accLoad_d;
      skip_q    <= flagClear & flag_q;
      if (iotHit) begin
        accOut_q <= accOut_d;
      end
    end
  end

  assign ioDone    = done_q;
  assign accOut    = accOut_q;
  assign accLoad   = accLoad_q;
  assign skipTaken = skip_q;

  // ---------------------------------------------------------------------------
  // active device reset
  // ---------------------------------------------------------------------------
  reg [PORTS-1:0] devReset_q;

  // software must follow a device change with this; nothing is automatic
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      devReset_q <= {PORTS{1'b0}};
    end else if (iotHit & (iotFunction == `FN_RESET_DEVICE)) begin
      // one pulse on the chosen port; the pattern assumes two ports
      devReset_q <= portSel ? 2'b10 : 2'b01;
    end else begin
      devReset_q <= {PORTS{1'b0}};
    end
  end

  assign resetActiveDevice = devReset_q;

endmodule // dual_port_comm_control_status

// ==== dual_port_comm_monitor.sv ====
// concurrent checks on the ports of the dual-port control and status block
`timescale 1ns/1ns
module dual_port_comm_monitor #(
  parameter PORTS = 2
) (
  input wire logic             clock,
  input wire logic             reset,
  input wire logic             iotStrobe,
  input wire logic [11:0]      iotCode,
  input wire logic [0:11]      accIn,
  input wire logic             ioDone,
  input wire logic [0:11]      accOut,
  input wire logic             accLoad,
  input wire logic             skipTaken,
  input wire logic [PORTS-1:0] requestToSend,
  input wire logic [PORTS-1:0] deviceSelect,
  input wire logic [PORTS-1:0] resetActiveDevice,
  input wire logic             modemChangeFlag,
  input wire logic             modemIrqEnable,
  input wire logic             modemIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------------
  // instruction sequences
  // ---------------------------------------------------------------------
  // an instruction of this block taken at an edge
  sequence take(logic [11:0] c);
    iotStrobe && iotCode == c;
  endsequence
  sequence takeAny;
    iotStrobe && iotCode[11:3] == 9'h19E;
  endsequence
  // ---------------------------------------------------------------------
  // answers
  // ---------------------------------------------------------------------
  a_answer_next: assert property (takeAny |=> ioDone)
    else $error("no answer one cycle after an instruction");
  a_no_stray_done: assert property (!(iotStrobe && iotCode[11:3] == 9'h19E)
    |=> !ioDone) else $error("answer without an instruction");
  a_status_read: assert property (take(12'hCF3)
    |=> accLoad && accOut[0] == $past(accIn[0]) && !accOut[1])
    else $error("status read word wrong");
  a_modem_read: assert property (take(12'hCF4)
    |=> accLoad && accOut[0:3] == {$past(accIn[0]), 3'b000})
    else $error("modem read word wrong");
  a_modem_rts: assert property (take(12'hCF4)
    |=> accOut[4] == ($past(accIn[0]) ? $past(requestToSend[1])
                                      : $past(requestToSend[0])))
    else $error("modem read request to send wrong");
  // control writes leave the accumulator untouched
  a_ctrl_keeps_acc: assert property (iotStrobe &&
    (iotCode == 12'hCF2 || iotCode == 12'hCF6)
    |=> !accLoad && accOut == $past(accIn))
    else $error("control write disturbed accumulator");
  a_ctrl_fields: assert property (take(12'hCF6) |=>
    deviceSelect[1] == $past(accIn[11]) && requestToSend[1] == $past(accIn[7]))
    else $error("port 1 control fields wrong");
  a_irq_enable_load: assert property (take(12'hCF5)
    |=> modemIrqEnable == $past(accIn[11]))
    else $error("interrupt enable not loaded");
  a_device_reset: assert property (take(12'hCF7)
    |=> resetActiveDevice == ($past(accIn[0]) ? 2'b10 : 2'b01))
    else $error("device reset on wrong port");
  // ---------------------------------------------------------------------
  // modem change flag
  // ---------------------------------------------------------------------
  a_skip_flag: assert property (take(12'hCF1)
    |=> skipTaken == $past(modemChangeFlag))
    else $error("skip does not follow the flag");
  a_flag_set: assert property (take(12'hCF0) |=> modemChangeFlag)
    else $error("flag not set");
  a_irq_gate: assert property
    (modemIrq == (modemChangeFlag && modemIrqEnable))
    else $error("interrupt request not flag and enable");
endmodule // dual_port_comm_monitor

// ==== host_iot_model.sv ====
// host processor model issuing io transfer instructions to the block
`timescale 1ns/1ns
module host_iot_model (
  input  wire logic        clock,
  output logic             iotStrobe,
  output logic [11:0]      iotCode,
  output logic [0:11]      accIn
);
  initial begin
    iotStrobe = 1'b0;
    iotCode = 12'h000;
    accIn = 12'h000;
  end
  // one instruction slot: driven after a falling edge, held across the
  // taking edge; an idle slot shows inverted values, never stale ones
  task automatic step(input logic go, input logic [11:0] code,
                      input logic [0:11] acc);
    iotStrobe = go;
    iotCode = go ? code : ~code;
    accIn = go ? acc : ~acc;
    @(negedge clock);
  endtask
  // a change of device is always followed at once by a device reset
  task automatic select_device(input logic port, input logic [0:11] acc);
    step(1'b1, port ? 12'hCF6 : 12'hCF2, acc);
    step(1'b1, 12'hCF7, {port, 11'h000});
  endtask
endmodule // host_iot_model

// ==== testbench.sv ====
// self-checking bench for the dual-port control and status block
`timescale 1ns/1ns
module testbench;
  logic        clock, reset, iotStrobe, ioDone, accLoad, skipTaken;
  logic [11:0] iotCode;
  logic [0:11] accIn, accOut;
  logic [1:0]  esdFitted, esdTxActive, esdRxActive, esdTxEmpty, scdTxEmptyN;
  logic [1:0]  esdRxAvail, scdRxAvailN, esdTxStatAvail, esdRxStatAvail;
  logic [1:0]  signalQuality, incomingCall, receiverReady, dataMode;
  logic [1:0]  clearToSend, termTimingEnable, esdTxEnable, esdRxEnable;
  logic [1:0]  requestToSend, terminalReady, signalRate, maintSelect;
  logic [1:0]  deviceSelect, resetActiveDevice;
  logic        modemChangeFlag, modemIrqEnable, modemIrq;
  logic [36:0] rows [0:7];
  int          errors, checkCount;
  host_iot_model host_iot_model_inst (.clock(clock), .iotStrobe(iotStrobe),
    .iotCode(iotCode), .accIn(accIn));
  dual_port_comm_control_status #(.PORTS(2))
    dual_port_comm_control_status_inst (
    .clock(clock), .reset(reset), .iotStrobe(iotStrobe), .iotCode(iotCode),
    .accIn(accIn), .ioDone(ioDone), .accOut(accOut), .accLoad(accLoad),
    .skipTaken(skipTaken), .esdFitted(esdFitted), .esdTxActive(esdTxActive),
    .esdRxActive(esdRxActive), .esdTxEmpty(esdTxEmpty),
    .scdTxEmptyN(scdTxEmptyN), .esdRxAvail(esdRxAvail),
    .scdRxAvailN(scdRxAvailN), .esdTxStatAvail(esdTxStatAvail),
    .esdRxStatAvail(esdRxStatAvail), .signalQuality(signalQuality),
    .incomingCall(incomingCall), .receiverReady(receiverReady),
    .dataMode(dataMode), .clearToSend(clearToSend),
    .termTimingEnable(termTimingEnable), .esdTxEnable(esdTxEnable),
    .esdRxEnable(esdRxEnable), .requestToSend(requestToSend),
    .terminalReady(terminalReady), .signalRate(signalRate),
    .maintSelect(maintSelect), .deviceSelect(deviceSelect),
    .resetActiveDevice(resetActiveDevice), .modemChangeFlag(modemChangeFlag),
    .modemIrqEnable(modemIrqEnable), .modemIrq(modemIrq));
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checkCount++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic step(input logic go, input logic [11:0] code,
                      input logic [0:11] acc);
    host_iot_model_inst.step(go, code, acc);
  endtask
  // control outputs of one port, in accumulator bit order 4..11
  function automatic logic [7:0] ctrl(input int p);
    return {termTimingEnable[p], esdTxEnable[p], esdRxEnable[p],
            requestToSend[p], terminalReady[p], signalRate[p],
            maintSelect[p], deviceSelect[p]};
  endfunction
  task automatic completeRun;
    $display("errors %0d checks %0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // watchdog, far beyond the 42 cycles the tests need
  initial begin
    #200000;
    errors++;
    completeRun();
  end
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    errors = 0;
    checkCount = 0;
    reset = 1'b1;
    {esdFitted, esdTxActive, esdRxActive, esdTxEmpty} = 8'b0101_0000;
    {scdTxEmptyN, esdRxAvail, scdRxAvailN} = 6'b10_0101;
    {esdTxStatAvail, esdRxStatAvail} = 4'b0001;
    {signalQuality, incomingCall, receiverReady} = 6'b01_1001;
    {dataMode, clearToSend} = 4'b0011;
    // code, accumulator in, accumulator out, load; port 1 has no
    // enhanced device, so its enhanced status bits read one
    rows = '{{12'hCF2, 12'h0A5, 12'h0A5, 1'b0},
             {12'hCF6, 12'hF1A, 12'hF1A, 1'b0},
             {12'hCF3, 12'h7FF, 12'h236, 1'b1},
             {12'hCF3, 12'hFFF, 12'hBED, 1'b1},
             {12'hCF4, 12'h7FF, 12'h035, 1'b1},
             {12'hCF4, 12'h800, 12'h8C9, 1'b1},
             {12'hCF5, 12'hFFE, 12'hFFE, 1'b0},
             {12'hCF3, 12'h800, 12'hBED, 1'b1}};
    repeat (16) @(negedge clock);
    check({ctrl(0), ctrl(1)}, 16'h0000);
    reset = 1'b0;
    // back to back instructions, one per cycle
    for (int i = 0; i < 8; i++) begin
      step(1'b1, rows[i][36:25], rows[i][24:13]);
      check(accOut, rows[i][12:1]);
      check({ioDone, accLoad}, {1'b1, rows[i][0]});
    end
    check({ctrl(0), ctrl(1)}, 16'hA51A);
    // device resets back to back, unused accumulator bits set on the second
    step(1'b1, 12'hCF7, 12'h800);
    check(resetActiveDevice, 2'b10);
    step(1'b1, 12'hCF7, 12'h7FF);
    check(resetActiveDevice, 2'b01);
    step(1'b1, 12'hCE3, 12'h800);
    check({ioDone, resetActiveDevice}, 3'b000);
    // flag, skip and interrupt
    step(1'b1, 12'hCF5, 12'h001);
    step(1'b1, 12'hCF1, 12'h000);
    step(1'b1, 12'hCF1, 12'h000);
    check({skipTaken, modemChangeFlag, modemIrqEnable}, 3'b001);
    step(1'b1, 12'hCF0, 12'h000);
    check({modemChangeFlag, modemIrq}, 2'b11);
    step(1'b1, 12'hCF1, 12'h000);
    check({skipTaken, modemChangeFlag, modemIrq}, 3'b100);
    dataMode[1] = 1'b1;
    step(1'b0, 12'h000, 12'h000);
    step(1'b0, 12'h000, 12'h000);
    check({modemChangeFlag, modemIrq}, 2'b11);
    step(1'b1, 12'hCF5, 12'hFFE);
    check({modemIrqEnable, modemIrq}, 2'b00);
    // switch port 0 back to the standard device
    host_iot_model_inst.select_device(1'b0, 12'h0A4);
    check({resetActiveDevice, ctrl(0)}, 10'h1A4);
    step(1'b1, 12'hCF3, 12'h000);
    check(accOut, 12'h234);
    // reset in mid-run clears the control registers
    step(1'b1, 12'hCF5, 12'h001);
    step(1'b0, 12'h000, 12'h000);
    reset = 1'b1;
    @(negedge clock);
    check({ctrl(0), ctrl(1), modemIrqEnable}, 17'h0_0000);
    reset = 1'b0;
    // an instruction at the first edge after release is legal
    step(1'b1, 12'hCF3, 12'h800);
    check({modemChangeFlag, accOut}, 13'h0BED);
    completeRun();
  end
endmodule // testbench

bind dual_port_comm_control_status dual_port_comm_monitor #(.PORTS(PORTS))
  dual_port_comm_monitor_inst (.clock(clock), .reset(reset),
  .iotStrobe(iotStrobe), .iotCode(iotCode), .accIn(accIn), .ioDone(ioDone),
  .accOut(accOut), .accLoad(accLoad), .skipTaken(skipTaken),
  .requestToSend(requestToSend), .deviceSelect(deviceSelect),
  .resetActiveDevice(resetActiveDevice), .modemChangeFlag(modemChangeFlag),
  .modemIrqEnable(modemIrqEnable), .modemIrq(modemIrq));
